// ==== sfpt_reader.sv ====
/*
 * discoverable-parameter table constants and lookup, and the byte
 * reader over it: takes a start address, presents one byte at a time
 * and steps on request.
 * assumes request inputs come from logic on the same clock.
 */
// Operation
// - byte 0Fh returns FFh, first header identifier is standards-defined
// - byte 10h returns 84h, low identifier of the four-byte-address table
// - byte 11h returns 00h, minor revision of the four-byte-address table
// - byte 12h returns 01h, original major revision of that table
// - byte 13h returns 02h, table length is two double words
// - bytes 14h to 16h return 40h, 03h, 00h: pointer to 0340h
// - byte 17h returns FFh, high identifier byte, standards-defined
// - basic byte 00h is E5h: unused ones, big buffer, uniform 4 KB erase
// - basic byte 00h bits 4:3 are 00b: volatile status write, non-volatile default
// - basic byte 01h returns 20h, the uniform 4 KB erase instruction
// - basic byte 02h is FBh: quad, dual, ddr and fast reads supported
// - basic byte 02h address field is 01b: three or four address bytes
// - basic byte 03h returns FFh filler
// - basic bytes 04h to 06h return FFh, low part of density 03FFFFFFh
// - basic table sits at base 0300h, relative offsets add to it
`timescale 1ns/1ps

package sfpt_pkg;

	localparam int          SFPT_AW  = 24;
	localparam int          SFPT_DW  = 8;
	localparam int          SFPT_LAT = 3;

	typedef enum logic [1:0] {
		SFPT_IDLE  = 2'h0,
		SFPT_FETCH = 2'h1,
		SFPT_LOAD  = 2'h3,
		SFPT_HOLD  = 2'h2
	} sfpt_state_type;

	// second parameter header
	localparam logic [23:0] SFPT_H1_ID_LO_ADDR   = 24'h00000F;
	localparam logic [23:0] SFPT_H1_ID_ADDR      = 24'h000010;
	localparam logic [23:0] SFPT_H1_MINOR_ADDR   = 24'h000011;
	localparam logic [23:0] SFPT_H1_MAJOR_ADDR   = 24'h000012;
	localparam logic [23:0] SFPT_H1_LEN_ADDR     = 24'h000013;
	localparam logic [23:0] SFPT_H1_PTR0_ADDR    = 24'h000014;
	localparam logic [23:0] SFPT_H1_PTR1_ADDR    = 24'h000015;
	localparam logic [23:0] SFPT_H1_PTR2_ADDR    = 24'h000016;
	localparam logic [23:0] SFPT_H1_ID_HI_ADDR   = 24'h000017;

	localparam logic [7:0]  SFPT_H1_ID_LO_VAL    = 8'hFF;
	localparam logic [7:0]  SFPT_H1_ID_VAL       = 8'h84;
	localparam logic [7:0]  SFPT_H1_MINOR_VAL    = 8'h00;
	localparam logic [7:0]  SFPT_H1_MAJOR_VAL    = 8'h01;
	localparam logic [7:0]  SFPT_H1_LEN_VAL      = 8'h02;
	localparam logic [23:0] SFPT_H1_PTR_VAL      = 24'h000340;
	localparam logic [7:0]  SFPT_H1_ID_HI_VAL    = 8'hFF;

	// basic table base and relative offsets
	localparam logic [23:0] SFPT_BASIC_BASE      = 24'h000300;
	localparam logic [23:0] SFPT_B_REL0          = 24'h000000;
	localparam logic [23:0] SFPT_B_REL1          = 24'h000001;
	localparam logic [23:0] SFPT_B_REL2          = 24'h000002;
	localparam logic [23:0] SFPT_B_REL3          = 24'h000003;
	localparam logic [23:0] SFPT_B_REL4          = 24'h000004;
	localparam logic [23:0] SFPT_B_REL5          = 24'h000005;
	localparam logic [23:0] SFPT_B_REL6          = 24'h000006;

	// basic byte 00h fields
	localparam logic [2:0]  SFPT_B0_UNUSED       = 3'h7;
	localparam logic [1:0]  SFPT_B0_STATUS_WR    = 2'h0;
	localparam logic [0:0]  SFPT_B0_BUF_GT64     = 1'h1;
	localparam logic [1:0]  SFPT_B0_ERASE_4K     = 2'h1;
	localparam int          SFPT_B0_UNUSED_LSB   = 5;
	localparam int          SFPT_B0_STWR_LSB     = 3;
	localparam int          SFPT_B0_BUF_BIT      = 2;
	localparam int          SFPT_B0_ERASE_LSB    = 0;

	localparam logic [7:0]  SFPT_ERASE_4K_INSTR  = 8'h20;

	// basic byte 02h fields, bit 16 of the double word is bit 0 here
	localparam logic [0:0]  SFPT_B2_UNUSED       = 1'h1;
	localparam logic [0:0]  SFPT_B2_QUAD_OUTPUT_READ = 1'h1;
	localparam logic [0:0]  SFPT_B2_QUAD_IO_READ = 1'h1;
	localparam logic [0:0]  SFPT_B2_DUAL_IO_READ = 1'h1;
	localparam logic [0:0]  SFPT_B2_DDR          = 1'h1;
	localparam logic [1:0]  SFPT_B2_ADDR_BYTES   = 2'h1;
	localparam logic [0:0]  SFPT_B2_FAST_READ    = 1'h1;
	localparam int          SFPT_B2_ADDR_LSB     = 1;

	localparam logic [7:0]  SFPT_B3_FILL         = 8'hFF;
	localparam logic [31:0] SFPT_DENSITY         = 32'h03FFFFFF;
	localparam logic [7:0]  SFPT_UNMAPPED        = 8'hFF;

	localparam logic [7:0]  SFPT_B0_VAL = {SFPT_B0_UNUSED, SFPT_B0_STATUS_WR,
		SFPT_B0_BUF_GT64, SFPT_B0_ERASE_4K};
	localparam logic [7:0]  SFPT_B2_VAL = {SFPT_B2_UNUSED, SFPT_B2_QUAD_OUTPUT_READ,
		SFPT_B2_QUAD_IO_READ, SFPT_B2_DUAL_IO_READ, SFPT_B2_DDR,
		SFPT_B2_ADDR_BYTES, SFPT_B2_FAST_READ};

	// {in table, byte}; addresses outside the covered bytes read as filler
	function automatic logic [8:0] sfpt_lookup(input logic [23:0] a);
		logic [8:0] r;
		r = {1'h1, SFPT_UNMAPPED};
		case (a)
			SFPT_H1_ID_LO_ADDR:             r[7:0] = SFPT_H1_ID_LO_VAL;
			SFPT_H1_ID_ADDR:                r[7:0] = SFPT_H1_ID_VAL;
			SFPT_H1_MINOR_ADDR:             r[7:0] = SFPT_H1_MINOR_VAL;
			SFPT_H1_MAJOR_ADDR:             r[7:0] = SFPT_H1_MAJOR_VAL;
			SFPT_H1_LEN_ADDR:               r[7:0] = SFPT_H1_LEN_VAL;
			SFPT_H1_PTR0_ADDR:              r[7:0] = SFPT_H1_PTR_VAL[7:0];
			SFPT_H1_PTR1_ADDR:              r[7:0] = SFPT_H1_PTR_VAL[15:8];
			SFPT_H1_PTR2_ADDR:              r[7:0] = SFPT_H1_PTR_VAL[23:16];
			SFPT_H1_ID_HI_ADDR:             r[7:0] = SFPT_H1_ID_HI_VAL;
			SFPT_BASIC_BASE + SFPT_B_REL0:  r[7:0] = SFPT_B0_VAL;
			SFPT_BASIC_BASE + SFPT_B_REL1:  r[7:0] = SFPT_ERASE_4K_INSTR;
			SFPT_BASIC_BASE + SFPT_B_REL2:  r[7:0] = SFPT_B2_VAL;
			SFPT_BASIC_BASE + SFPT_B_REL3:  r[7:0] = SFPT_B3_FILL;
			SFPT_BASIC_BASE + SFPT_B_REL4:  r[7:0] = SFPT_DENSITY[7:0];
			SFPT_BASIC_BASE + SFPT_B_REL5:  r[7:0] = SFPT_DENSITY[15:8];
			SFPT_BASIC_BASE + SFPT_B_REL6:  r[7:0] = SFPT_DENSITY[23:16];
			default:                        r[8] = 1'h0;
		endcase
		return r;
	endfunction : sfpt_lookup

endpackage : sfpt_pkg

module sfpt_reader
	import sfpt_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        rd_start,
	input  wire logic [23:0] rd_addr,
	input  wire logic        rd_next,
	input  wire logic        rd_stop,
	output logic      [7:0]  rd_data,
	output logic             rd_valid,
	output logic             rd_known
);

	typedef struct packed {
		sfpt_state_type st;
		logic [23:0]    addr;
		logic [7:0]     data;
		logic           valid;
		logic           known;
	} sfpt_reader_type;

	sfpt_reader_type rdr_r;
	sfpt_reader_type rdr_nxt;
	logic [7:0]      rom_data;
	logic            rom_known;
	logic            rom_en;

	assign rom_en = (rdr_r.st == SFPT_FETCH);

	sfpt_rom u_rom (
		.clock (clock),
		.rst   (rst),
		.rd_en (rom_en),
		.addr  (rdr_r.addr),
		.data  (rom_data),
		.known (rom_known)
	);

	// start wins over stop, stop wins over step
	always_comb begin
		rdr_nxt = rdr_r;
		case (rdr_r.st)
			SFPT_IDLE: begin
				rdr_nxt.valid = 1'h0;
			end
			SFPT_FETCH: begin
				rdr_nxt.st = SFPT_LOAD;
			end
			SFPT_LOAD: begin
				rdr_nxt.data  = rom_data;
				rdr_nxt.known = rom_known;
				rdr_nxt.valid = 1'h1;
				rdr_nxt.st    = SFPT_HOLD;
			end
			SFPT_HOLD: begin
				if (rd_next) begin
					// wraps at the top of the 24-bit space
					rdr_nxt.addr  = rdr_r.addr + 24'h000001;
					rdr_nxt.valid = 1'h0;
					rdr_nxt.st    = SFPT_FETCH;
				end
			end
			default: begin
				rdr_nxt.st = SFPT_IDLE;
			end
		endcase
		if (rd_stop) begin
			rdr_nxt.st    = SFPT_IDLE;
			rdr_nxt.valid = 1'h0;
		end
		if (rd_start) begin
			rdr_nxt.addr  = rd_addr;
			rdr_nxt.valid = 1'h0;
			rdr_nxt.st    = SFPT_FETCH;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdr_r <= '{st: SFPT_IDLE, addr: 24'h000000, data: 8'h00,
				valid: 1'h0, known: 1'h0};
		end else begin
			rdr_r <= rdr_nxt;
		end
	end

	assign rd_data  = rdr_r.data;
	assign rd_valid = rdr_r.valid;
	assign rd_known = rdr_r.known;

	// byte shown three edges after a clean start
	chk_start_latency: assert property (@(posedge clock) disable iff (rst)
		rd_start ##1 (!rd_start && !rd_stop)[*2] |=> rd_valid && !$past(rd_valid))
		else $error("valid not raised after start");

	chk_hdr_id_lo: assert property (@(posedge clock) disable iff (rst)
		rd_start && rd_addr == SFPT_H1_ID_LO_ADDR ##1 (!rd_start && !rd_stop)[*2]
		|=> rd_valid && rd_known && rd_data == SFPT_H1_ID_LO_VAL)
		else $error("header byte 0F wrong");

	chk_hdr_id: assert property (@(posedge clock) disable iff (rst)
		rd_start && rd_addr == SFPT_H1_ID_ADDR ##1 (!rd_start && !rd_stop)[*2]
		|=> rd_valid && rd_data == SFPT_H1_ID_VAL)
		else $error("header byte 10 wrong");

	chk_hdr_minor: assert property (@(posedge clock) disable iff (rst)
		rd_start && rd_addr == SFPT_H1_MINOR_ADDR ##1 (!rd_start && !rd_stop)[*2]
		|=> rd_valid && rd_data == SFPT_H1_MINOR_VAL)
		else $error("header byte 11 wrong");

	chk_hdr_major: assert property (@(posedge clock) disable iff (rst)
		rd_start && rd_addr == SFPT_H1_MAJOR_ADDR ##1 (!rd_start && !rd_stop)[*2]
		|=> rd_valid && rd_data == SFPT_H1_MAJOR_VAL)
		else $error("header byte 12 wrong");

	chk_hdr_length: assert property (@(posedge clock) disable iff (rst)
		rd_start && rd_addr == SFPT_H1_LEN_ADDR ##1 (!rd_start && !rd_stop)[*2]
		|=> rd_valid && rd_data == SFPT_H1_LEN_VAL)
		else $error("header byte 13 wrong");

	// a step from the first pointer byte must show the second
	chk_hdr_pointer: assert property (@(posedge clock) disable iff (rst)
		rdr_r.st == SFPT_HOLD && rdr_r.addr == SFPT_H1_PTR0_ADDR && rd_next
		&& !rd_start && !rd_stop ##1 (!rd_start && !rd_stop)[*2]
		|=> rd_valid && rd_data == SFPT_H1_PTR_VAL[15:8])
		else $error("header pointer bytes wrong");

	chk_hdr_ptr_top: assert property (@(posedge clock) disable iff (rst)
		rd_start && rd_addr == SFPT_H1_PTR2_ADDR ##1 (!rd_start && !rd_stop)[*2]
		|=> rd_valid && rd_data == SFPT_H1_PTR_VAL[23:16])
		else $error("header byte 16 wrong");

	chk_hdr_id_hi: assert property (@(posedge clock) disable iff (rst)
		rd_start && rd_addr == SFPT_H1_ID_HI_ADDR ##1 (!rd_start && !rd_stop)[*2]
		|=> rd_valid && rd_data == SFPT_H1_ID_HI_VAL)
		else $error("header byte 17 wrong");

	chk_basic_erase: assert property (@(posedge clock) disable iff (rst)
		rd_start && rd_addr == SFPT_BASIC_BASE + SFPT_B_REL0
		##1 (!rd_start && !rd_stop)[*2]
		|=> rd_valid && rd_data == SFPT_B0_VAL
		&& rd_data[SFPT_B0_BUF_BIT] == SFPT_B0_BUF_GT64
		&& rd_data[SFPT_B0_ERASE_LSB +: 2] == SFPT_B0_ERASE_4K
		&& rd_data[SFPT_B0_UNUSED_LSB +: 3] == SFPT_B0_UNUSED)
		else $error("basic byte 00 fields wrong");

	chk_basic_status: assert property (@(posedge clock) disable iff (rst)
		rd_start && rd_addr == SFPT_BASIC_BASE + SFPT_B_REL0
		##1 (!rd_start && !rd_stop)[*2]
		|=> rd_data[SFPT_B0_STWR_LSB +: 2] == SFPT_B0_STATUS_WR)
		else $error("status write type wrong");

	chk_basic_instr: assert property (@(posedge clock) disable iff (rst)
		rd_start && rd_addr == SFPT_BASIC_BASE + SFPT_B_REL1
		##1 (!rd_start && !rd_stop)[*2]
		|=> rd_valid && rd_data == SFPT_ERASE_4K_INSTR)
		else $error("erase instruction byte wrong");

	chk_basic_reads: assert property (@(posedge clock) disable iff (rst)
		rd_start && rd_addr == SFPT_BASIC_BASE + SFPT_B_REL2
		##1 (!rd_start && !rd_stop)[*2]
		|=> rd_valid && rd_data == SFPT_B2_VAL)
		else $error("read support byte wrong");

	chk_basic_addr: assert property (@(posedge clock) disable iff (rst)
		rd_start && rd_addr == SFPT_BASIC_BASE + SFPT_B_REL2
		##1 (!rd_start && !rd_stop)[*2]
		|=> rd_data[SFPT_B2_ADDR_LSB +: 2] == SFPT_B2_ADDR_BYTES)
		else $error("address byte field wrong");

	chk_basic_fill: assert property (@(posedge clock) disable iff (rst)
		rd_start && rd_addr == SFPT_BASIC_BASE + SFPT_B_REL3
		##1 (!rd_start && !rd_stop)[*2]
		|=> rd_valid && rd_data == SFPT_B3_FILL)
		else $error("basic byte 03 wrong");

	chk_basic_density: assert property (@(posedge clock) disable iff (rst)
		rd_start && rd_addr == SFPT_BASIC_BASE + SFPT_B_REL4
		##1 (!rd_start && !rd_stop)[*2]
		|=> rd_valid && rd_known && rd_data == SFPT_DENSITY[7:0])
		else $error("density byte wrong");

	// a step from the base must land on relative byte 01h
	chk_basic_base: assert property (@(posedge clock) disable iff (rst)
		rdr_r.st == SFPT_HOLD && rdr_r.addr == SFPT_BASIC_BASE && rd_next
		&& !rd_start && !rd_stop ##1 (!rd_start && !rd_stop)[*2]
		|=> rd_valid && rd_data == SFPT_ERASE_4K_INSTR)
		else $error("basic table not at its base");

	// shown byte holds until the reader moves on
	chk_data_stable: assert property (@(posedge clock) disable iff (rst)
		rd_valid && !rd_start && !rd_stop && !rd_next
		|=> rd_valid && $stable(rd_data))
		else $error("shown byte changed while held");

	chk_stop_idle: assert property (@(posedge clock) disable iff (rst)
		rd_stop && !rd_start |=> !rd_valid ##1 !rd_valid)
		else $error("valid after stop");

	chk_unknown_fill: assert property (@(posedge clock) disable iff (rst)
		rd_valid && !rd_known |-> rd_data == SFPT_UNMAPPED)
		else $error("uncovered address not filler");

endmodule : sfpt_reader

// ==== sfpt_rom.sv ====
/*
 * small registered-read rom over the discoverable-parameter table.
 * assumes one clock and an active-high asynchronous reset shared with
 * the reader that instantiates it, and the table package read first.
 */
`timescale 1ns/1ps

module sfpt_rom
	import sfpt_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        rd_en,
	input  wire logic [23:0] addr,
	output logic      [7:0]  data,
	output logic             known
);

	typedef struct packed {
		logic [7:0] data;
		logic       known;
	} sfpt_rom_type;

	sfpt_rom_type rom_r;
	sfpt_rom_type rom_nxt;

	// no write port at all, so nothing can alter the content
	always_comb begin
		rom_nxt = rom_r;
		if (rd_en) begin
			{rom_nxt.known, rom_nxt.data} = sfpt_lookup(addr);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rom_r <= '0;
		end else begin
			rom_r <= rom_nxt;
		end
	end

	assign data  = rom_r.data;
	assign known = rom_r.known;

endmodule : sfpt_rom

// ==== sfpt_host_model.sv ====
/*
 * host-side reader model: issues start, next and stop requests to the
 * byte reader and reports what comes back.
 * assumes the reader samples its inputs on the rising clock edge.
 */
`timescale 1ns/1ps

module sfpt_host_model (
	input  wire logic        clock,
	output logic             rd_start,
	output logic      [23:0] rd_addr,
	output logic             rd_next,
	output logic             rd_stop,
	input  wire logic [7:0]  rd_data,
	input  wire logic        rd_valid,
	input  wire logic        rd_known
);

	initial begin
		rd_start = 1'h0;
		rd_addr  = 24'h000000;
		rd_next  = 1'h0;
		rd_stop  = 1'h0;
	end

	// kind 0 start, 1 next, 2 stop, 3 start and stop together
	// lat counts cycles until valid shows, 8 means it never did
	task automatic request(input int kind, input logic [23:0] a, output logic drop,
		output int lat, output logic [7:0] d, output logic k);
		@(negedge clock);
		rd_start <= (kind == 0) || (kind == 3);
		rd_stop  <= (kind >= 2);
		rd_next  <= (kind == 1);
		rd_addr  <= a;
		@(negedge clock);
		rd_start <= 1'h0;
		rd_stop  <= 1'h0;
		rd_next  <= 1'h0;
		// released: scramble so a late sample of the address shows
		rd_addr  <= ~a;
		drop = rd_valid;
		// the request cycle is cycle 0, so this one is cycle 1
		lat = 1;
		while (lat < 8 && rd_valid !== 1'h1) begin
			@(negedge clock);
			lat++;
		end
		d = rd_data;
		k = rd_known;
	endtask : request

endmodule : sfpt_host_model

// ==== tb_top.sv ====
/*
 * self-checking bench for the parameter-table byte reader.
 * assumes the reader answers exactly three edges after each start, or step from a shown byte.
 */
`timescale 1ns/1ps

module tb_top;

	logic        clock;
	logic        rst;
	logic        rd_start;
	logic [23:0] rd_addr;
	logic        rd_next;
	logic        rd_stop;
	logic [7:0]  rd_data;
	logic        rd_valid;
	logic        rd_known;
	int          num_errors   = 0;
	int          total_checks = 0;

	initial begin
		clock = 1'h0;
		forever #2.5 clock = ~clock;
	end

	sfpt_reader dut (
		.clock    (clock),
		.rst      (rst),
		.rd_start (rd_start),
		.rd_addr  (rd_addr),
		.rd_next  (rd_next),
		.rd_stop  (rd_stop),
		.rd_data  (rd_data),
		.rd_valid (rd_valid),
		.rd_known (rd_known)
	);

	sfpt_host_model host (
		.clock    (clock),
		.rd_start (rd_start),
		.rd_addr  (rd_addr),
		.rd_next  (rd_next),
		.rd_stop  (rd_stop),
		.rd_data  (rd_data),
		.rd_valid (rd_valid),
		.rd_known (rd_known)
	);

	task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check8

	task automatic check1(input string name, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %b seen %b", name, exp, got);
		end
	endtask : check1

	task automatic check_n(input string name, input int exp, input int got);
		total_checks++;
		if (got != exp) begin
			num_errors++;
			$display("mismatch %s expected %0d seen %0d", name, exp, got);
		end
	endtask : check_n

	// one request that must answer in three cycles with the given byte
	task automatic step(input int kind, input logic [23:0] a, input logic [7:0] exp,
		input logic expk, output logic [7:0] d);
		logic drop;
		int   lat;
		logic k;
		host.request(kind, a, drop, lat, d, k);
		check1("rd_valid drop", 1'h0, drop);
		check_n("latency", 3, lat);
		check8("rd_data", exp, d);
		check1("rd_known", expk, k);
	endtask : step

	// a request that must leave the reader idle
	task automatic quiet(input int kind);
		logic       drop;
		int         lat;
		logic [7:0] d;
		logic       k;
		host.request(kind, 24'h000300, drop, lat, d, k);
		check1("rd_valid idle", 1'h0, drop);
		check_n("no answer", 8, lat);
	endtask : quiet

	task automatic check_reset_outputs;
		check8("rd_data reset", 8'h00, rd_data);
		check1("rd_valid reset", 1'h0, rd_valid);
		check1("rd_known reset", 1'h0, rd_known);
	endtask : check_reset_outputs

	task automatic test_header;
		logic [7:0] exp [9] = '{8'hFF, 8'h84, 8'h00, 8'h01, 8'h02, 8'h40, 8'h03, 8'h00, 8'hFF};
		logic [7:0] d;
		step(0, 24'h00000F, exp[0], 1'h1, d);
		for (int i = 1; i < 9; i++) begin
			step(1, 24'h000000, exp[i], 1'h1, d);
		end
		quiet(2);
	endtask : test_header

	task automatic test_basic;
		logic [7:0] exp [7] = '{8'hE5, 8'h20, 8'hFB, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
		logic [7:0] d [7];
		step(0, 24'h000300, exp[0], 1'h1, d[0]);
		step(1, 24'h000000, exp[1], 1'h1, d[1]);
		step(1, 24'h000000, exp[2], 1'h1, d[2]);
		for (int i = 3; i < 7; i++) begin
			step(1, 24'h000000, exp[i], 1'h1, d[i]);
		end
		check8("status write field", 8'h00, {6'h00, d[0][4:3]});
		check8("erase field", 8'h01, {6'h00, d[0][1:0]});
		check8("address bytes field", 8'h01, {6'h00, d[2][2:1]});
		step(1, 24'h000000, 8'hFF, 1'h0, d[0]);
		quiet(2);
	endtask : test_basic

	task automatic test_edges;
		logic [7:0] d;
		step(0, 24'h00000E, 8'hFF, 1'h0, d);
		step(1, 24'h000000, 8'hFF, 1'h1, d);
		step(0, 24'h0002FF, 8'hFF, 1'h0, d);
		step(1, 24'h000000, 8'hE5, 1'h1, d);
		// restart while a byte is shown
		step(0, 24'h000010, 8'h84, 1'h1, d);
		// start wins over stop in the same cycle
		step(3, 24'h000013, 8'h02, 1'h1, d);
		quiet(2);
	endtask : test_edges

	task automatic test_refuse;
		logic [7:0] d;
		quiet(1);
		step(0, 24'h000301, 8'h20, 1'h1, d);
		quiet(2);
	endtask : test_refuse

	task automatic test_fixed;
		logic [7:0] d;
		step(0, 24'h000302, 8'hFB, 1'h1, d);
		@(negedge clock);
		rst = 1'h1;
		#1;
		check_reset_outputs();
		repeat (2) @(negedge clock);
		rst = 1'h0;
		step(0, 24'h000302, 8'hFB, 1'h1, d);
		step(0, 24'h000016, 8'h00, 1'h1, d);
		step(0, 24'h000306, 8'hFF, 1'h1, d);
		step(0, 24'h000011, 8'h00, 1'h1, d);
		step(0, 24'h000012, 8'h01, 1'h1, d);
		step(0, 24'h000017, 8'hFF, 1'h1, d);
		step(0, 24'h000303, 8'hFF, 1'h1, d);
		step(0, 24'h000304, 8'hFF, 1'h1, d);
	endtask : test_fixed

	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test

	// the whole sequence needs well under a thousand cycles
	initial begin
		#20000;
		num_errors++;
		$display("mismatch watchdog expected done seen timeout");
		finish_test();
	end

	initial begin
		rst = 1'h1;
		repeat (2) @(negedge clock);
		check_reset_outputs();
		rst = 1'h0;
		test_header();
		test_basic();
		test_edges();
		test_refuse();
		test_fixed();
		finish_test();
	end

endmodule : tb_top
